//--- hw/cms_map.svh
`ifndef CMS_MAP_SVH
`define CMS_MAP_SVH
// register bus indexes
`define CMS_REG_ACC 4'h0
`define CMS_REG_STATUS 4'h1
`define CMS_REG_BANK 4'h2
`define CMS_REG_LATCH 4'h3
`define CMS_REG_OPTION 4'h4
`define CMS_REG_PTR0_LO 4'h5
`define CMS_REG_PTR0_HI 4'h6
`define CMS_REG_PTR1_LO 4'h7
`define CMS_REG_PTR1_HI 4'h8
`define CMS_REG_POWER_CTRL_REG 4'h9
`define CMS_REG_IRQ 4'hA
`define CMS_REG_PC_LO 4'hB
`define CMS_REG_PC_HI 4'hC
// field positions
`define CMS_STAT_C 0
`define CMS_STAT_Z 2
`define CMS_POWER_CTRL_REG_SRF 2
`define CMS_IRQ_GIE 7
// indirect port file addresses
`define CMS_PORT0 7'h00
`define CMS_PORT1 7'h01
// destination bit values
`define CMS_DEST_ACC 1'b0
`define CMS_DEST_FILE 1'b1
// pointer update modes
`define CMS_MODE_PREINC 2'b00
`define CMS_MODE_PREDEC 2'b01
`define CMS_MODE_POSTINC 2'b10
`define CMS_MODE_POSTDEC 2'b11
// reset values
`define CMS_RST_BYTE 8'h00
`define CMS_RST_OPTION 8'hFF
`define CMS_RST_PTR 16'h0000
`define CMS_RST_PC 15'h0000
`define CMS_RST_BANK 5'h00
`define CMS_RST_LATCH 7'h00
`endif

//--- hw/cms_pkg.sv
package cms_pkg;
  typedef enum logic [4:0] {
    CMS_OP_NOP = 5'b00000,
    CMS_OP_SHL = 5'b00001,
    CMS_OP_SHR = 5'b00010,
    CMS_OP_FMOVE = 5'b00011,
    CMS_OP_ILOAD = 5'b00100,
    CMS_OP_ISTORE = 5'b00101,
    CMS_OP_BANK = 5'b00110,
    CMS_OP_LATCH = 5'b00111,
    CMS_OP_LIT = 5'b01000,
    CMS_OP_STORE = 5'b01001,
    CMS_OP_OPTION = 5'b01010,
    CMS_OP_SRESET = 5'b01011,
    CMS_OP_RETI = 5'b01100,
    CMS_OP_RET = 5'b01101,
    CMS_OP_RETLIT = 5'b01110,
    CMS_OP_ROL = 5'b01111,
    CMS_OP_ROR = 5'b10000,
    CMS_OP_CALL = 5'b10001
  } cms_op_t;

  typedef enum logic [1:0] {
    CMS_S_IDLE = 2'b00,
    CMS_S_READ = 2'b01,
    CMS_S_EXEC = 2'b10,
    CMS_S_TWO = 2'b11
  } cms_state_t;
endpackage

//--- hw/cms_core.sv
`timescale 1ns/1ps
`include "cms_map.svh"

module cms_core
  import cms_pkg::*;
#(
  parameter int PC_W = 15
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic instr_valid,
  input wire cms_op_t instr_op,
  input wire logic [6:0] instr_file,
  input wire logic instr_dest,
  input wire logic [10:0] instr_lit,
  input wire logic instr_ptr_sel,
  input wire logic [1:0] instr_mode,
  input wire logic instr_indexed,
  input wire logic [5:0] instr_offset,
  output logic instr_ready,
  output logic instr_done,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic stack_push,
  output logic [PC_W-1:0] stack_push_data,
  output logic stack_pop,
  input wire logic [PC_W-1:0] stack_top_entry,
  output logic dev_reset,
  output logic global_irq_enable,
  output logic [7:0] option_out,
  output logic [4:0] bank_select,
  output logic [PC_W-1:0] pc_out,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // state and storage
  cms_state_t state_ff, nxt_state;
  cms_op_t op_ff;
  logic dest_ff;
  logic rdy_ff, done_ff, soft_rst_ff;
  logic [7:0] acc_ff, option_ff, irq_ff, rdata_ff, wdata_ff;
  logic carry_ff, zero_ff, srf_ff;
  logic [4:0] bank_ff;
  logic [6:0] latch_ff;
  logic [PC_W-1:0] pc_ff, push_data_ff;
  logic [15:0] ptr_ff [2];
  logic [15:0] addr_ff;
  logic rd_ff, wr_ff, push_ff, pop_ff;
  logic rst_all;

  assign rst_all = srst | soft_rst_ff;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the accepted instruction
  logic accept, is_ind, is_read, is_two, is_store;
  logic [15:0] ptr_sel_val, ptr_step, ind_addr, eff_addr, dir_addr;

  assign accept = instr_valid & rdy_ff;
  assign is_ind = (instr_op == CMS_OP_ILOAD) | (instr_op == CMS_OP_ISTORE);
  assign is_read = (instr_op == CMS_OP_SHL) | (instr_op == CMS_OP_SHR) |
    (instr_op == CMS_OP_FMOVE) | (instr_op == CMS_OP_ILOAD) |
    (instr_op == CMS_OP_ROL) | (instr_op == CMS_OP_ROR);
  assign is_two = (instr_op == CMS_OP_RETI) | (instr_op == CMS_OP_RET) |
    (instr_op == CMS_OP_RETLIT) | (instr_op == CMS_OP_CALL);
  assign is_store = (instr_op == CMS_OP_STORE) | (instr_op == CMS_OP_ISTORE);
  assign ptr_sel_val = ptr_ff[instr_ptr_sel];
  // wraps modulo 2^16
  assign ptr_step = instr_mode[0] ? ptr_sel_val - 16'h0001 : ptr_sel_val + 16'h0001;

  always_comb begin
    if (instr_indexed) begin
      ind_addr = ptr_sel_val + {{10{instr_offset[5]}}, instr_offset};
    end else if (instr_mode[1]) begin
      ind_addr = ptr_sel_val;
    end else begin
      ind_addr = ptr_step;
    end
  end

  // indirect port addresses redirect through the pointers
  always_comb begin
    if (instr_file == `CMS_PORT0) begin
      dir_addr = ptr_ff[0];
    end else if (instr_file == `CMS_PORT1) begin
      dir_addr = ptr_ff[1];
    end else begin
      dir_addr = {4'h0, bank_ff, instr_file};
    end
  end

  assign eff_addr = is_ind ? ind_addr : dir_addr;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CMS_S_IDLE: begin
        if (accept && is_read) begin
          nxt_state = CMS_S_READ;
        end else if (accept && is_two) begin
          nxt_state = CMS_S_TWO;
        end
      end
      CMS_S_READ: nxt_state = CMS_S_EXEC;
      CMS_S_EXEC: nxt_state = CMS_S_IDLE;
      CMS_S_TWO: nxt_state = CMS_S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      state_ff <= CMS_S_IDLE;
      rdy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rdy_ff <= (nxt_state == CMS_S_IDLE) && !(accept && instr_op == CMS_OP_SRESET);
      done_ff <= (accept && !is_read && !is_two) || (state_ff == CMS_S_EXEC) ||
        (state_ff == CMS_S_TWO);
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      op_ff <= CMS_OP_NOP;
      dest_ff <= `CMS_DEST_ACC;
    end else if (accept) begin
      op_ff <= instr_op;
      dest_ff <= instr_dest;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // execute stage datapath
  logic exec;
  logic [7:0] result;
  logic res_carry;

  assign exec = (state_ff == CMS_S_EXEC);

  always_comb begin
    result = mem_rdata;
    res_carry = carry_ff;
    unique case (op_ff)
      CMS_OP_SHL: begin
        result = {mem_rdata[6:0], 1'b0};
        res_carry = mem_rdata[7];
      end
      CMS_OP_SHR: begin
        result = {1'b0, mem_rdata[7:1]};
        res_carry = mem_rdata[0];
      end
      CMS_OP_ROL: begin
        result = {mem_rdata[6:0], carry_ff};
        res_carry = mem_rdata[7];
      end
      CMS_OP_ROR: begin
        result = {carry_ff, mem_rdata[7:1]};
        res_carry = mem_rdata[0];
      end
      default: begin
        result = mem_rdata;
        res_carry = carry_ff;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // data memory port
  logic exec_wr;

  assign exec_wr = exec && (dest_ff == `CMS_DEST_FILE) && (op_ff != CMS_OP_ILOAD);

  always_ff @(posedge clk) begin
    if (rst_all) begin
      addr_ff <= `CMS_RST_PTR;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      wdata_ff <= `CMS_RST_BYTE;
    end else begin
      rd_ff <= accept && is_read;
      wr_ff <= (accept && is_store) || exec_wr;
      if (accept && (is_read || is_store)) begin
        addr_ff <= eff_addr;
      end
      if (accept) begin
        wdata_ff <= acc_ff;
      end else if (exec_wr) begin
        wdata_ff <= result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator
  always_ff @(posedge clk) begin
    if (rst_all) begin
      acc_ff <= `CMS_RST_BYTE;
    end else if (exec && (op_ff == CMS_OP_ILOAD)) begin
      acc_ff <= mem_rdata;
    end else if (exec && (dest_ff == `CMS_DEST_ACC)) begin
      acc_ff <= result;
    end else if (accept && (instr_op == CMS_OP_LIT || instr_op == CMS_OP_RETLIT)) begin
      acc_ff <= instr_lit[7:0];
    end else if (reg_wr && reg_addr == `CMS_REG_ACC) begin
      acc_ff <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags
  logic sets_z, sets_c;

  assign sets_z = (op_ff == CMS_OP_SHL) || (op_ff == CMS_OP_SHR) ||
    (op_ff == CMS_OP_FMOVE) || (op_ff == CMS_OP_ILOAD);
  assign sets_c = (op_ff == CMS_OP_SHL) || (op_ff == CMS_OP_SHR) ||
    (op_ff == CMS_OP_ROL) || (op_ff == CMS_OP_ROR);

  always_ff @(posedge clk) begin
    if (rst_all) begin
      carry_ff <= 1'b0;
      zero_ff <= 1'b0;
    end else begin
      if (exec && sets_c) begin
        carry_ff <= res_carry;
      end else if (reg_wr && reg_addr == `CMS_REG_STATUS) begin
        carry_ff <= reg_wdata[`CMS_STAT_C];
      end
      if (exec && sets_z) begin
        zero_ff <= (result == 8'h00);
      end else if (reg_wr && reg_addr == `CMS_REG_STATUS) begin
        zero_ff <= reg_wdata[`CMS_STAT_Z];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bank, latch, option, interrupt control
  always_ff @(posedge clk) begin
    if (rst_all) begin
      bank_ff <= `CMS_RST_BANK;
      latch_ff <= `CMS_RST_LATCH;
      option_ff <= `CMS_RST_OPTION;
    end else begin
      if (accept && instr_op == CMS_OP_BANK) begin
        bank_ff <= instr_lit[4:0];
      end else if (reg_wr && reg_addr == `CMS_REG_BANK) begin
        bank_ff <= reg_wdata[4:0];
      end
      if (accept && instr_op == CMS_OP_LATCH) begin
        latch_ff <= instr_lit[6:0];
      end else if (reg_wr && reg_addr == `CMS_REG_LATCH) begin
        latch_ff <= reg_wdata[6:0];
      end
      if (accept && instr_op == CMS_OP_OPTION) begin
        option_ff <= acc_ff;
      end else if (reg_wr && reg_addr == `CMS_REG_OPTION) begin
        option_ff <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst_all) begin
      irq_ff <= `CMS_RST_BYTE;
    end else if (accept && instr_op == CMS_OP_RETI) begin
      irq_ff[`CMS_IRQ_GIE] <= 1'b1;
    end else if (reg_wr && reg_addr == `CMS_REG_IRQ) begin
      irq_ff <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointers
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ptr
      always_ff @(posedge clk) begin
        if (rst_all) begin
          ptr_ff[gi] <= `CMS_RST_PTR;
        end else if (accept && is_ind && !instr_indexed && instr_ptr_sel == gi) begin
          ptr_ff[gi] <= ptr_step;
        end else if (reg_wr && reg_addr == `CMS_REG_PTR0_LO + 4'(2 * gi)) begin
          ptr_ff[gi][7:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == `CMS_REG_PTR0_HI + 4'(2 * gi)) begin
          ptr_ff[gi][15:8] <= reg_wdata;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // program counter and return stack
  always_ff @(posedge clk) begin
    if (rst_all) begin
      pc_ff <= `CMS_RST_PC;
      push_ff <= 1'b0;
      pop_ff <= 1'b0;
      push_data_ff <= `CMS_RST_PC;
    end else begin
      push_ff <= accept && instr_op == CMS_OP_CALL;
      pop_ff <= accept && (instr_op == CMS_OP_RETI || instr_op == CMS_OP_RET ||
        instr_op == CMS_OP_RETLIT);
      if (accept && instr_op == CMS_OP_CALL) begin
        push_data_ff <= pc_ff + PC_W'(1);
      end
      if (accept) begin
        unique case (instr_op)
          CMS_OP_RETI, CMS_OP_RET, CMS_OP_RETLIT: pc_ff <= stack_top_entry;
          CMS_OP_CALL: pc_ff <= {latch_ff[6:3], instr_lit};
          default: pc_ff <= pc_ff + PC_W'(1);
        endcase
      end else if (reg_wr && reg_addr == `CMS_REG_PC_LO) begin
        pc_ff[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == `CMS_REG_PC_HI) begin
        pc_ff[PC_W-1:8] <= reg_wdata[PC_W-9:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software reset
  always_ff @(posedge clk) begin
    if (srst) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= accept && instr_op == CMS_OP_SRESET;
    end
  end

  // not in rst_all, but the soft reset instruction clears it; a power-up reset sets it
  always_ff @(posedge clk) begin
    if (srst) begin
      srf_ff <= 1'b1;
    end else if (accept && instr_op == CMS_OP_SRESET) begin
      srf_ff <= 1'b0;
    end else if (reg_wr && reg_addr == `CMS_REG_POWER_CTRL_REG) begin
      srf_ff <= reg_wdata[`CMS_POWER_CTRL_REG_SRF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= `CMS_RST_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `CMS_REG_ACC: rdata_ff <= acc_ff;
        `CMS_REG_STATUS: rdata_ff <= 8'((zero_ff << `CMS_STAT_Z) | (carry_ff << `CMS_STAT_C));
        `CMS_REG_BANK: rdata_ff <= {3'h0, bank_ff};
        `CMS_REG_LATCH: rdata_ff <= {1'b0, latch_ff};
        `CMS_REG_OPTION: rdata_ff <= option_ff;
        `CMS_REG_PTR0_LO: rdata_ff <= ptr_ff[0][7:0];
        `CMS_REG_PTR0_HI: rdata_ff <= ptr_ff[0][15:8];
        `CMS_REG_PTR1_LO: rdata_ff <= ptr_ff[1][7:0];
        `CMS_REG_PTR1_HI: rdata_ff <= ptr_ff[1][15:8];
        `CMS_REG_POWER_CTRL_REG: rdata_ff <= 8'(srf_ff << `CMS_POWER_CTRL_REG_SRF);
        `CMS_REG_IRQ: rdata_ff <= irq_ff;
        `CMS_REG_PC_LO: rdata_ff <= pc_ff[7:0];
        `CMS_REG_PC_HI: rdata_ff <= 8'(pc_ff[PC_W-1:8]);
        default: rdata_ff <= `CMS_RST_BYTE;
      endcase
    end else begin
      rdata_ff <= `CMS_RST_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign instr_ready = rdy_ff;
  assign instr_done = done_ff;
  assign mem_addr = addr_ff;
  assign mem_rd = rd_ff;
  assign mem_wr = wr_ff;
  assign mem_wdata = wdata_ff;
  assign stack_push = push_ff;
  assign stack_push_data = push_data_ff;
  assign stack_pop = pop_ff;
  assign dev_reset = soft_rst_ff;
  assign global_irq_enable = irq_ff[`CMS_IRQ_GIE];
  assign option_out = option_ff;
  assign bank_select = bank_ff;
  assign pc_out = pc_ff;
  assign reg_rdata = rdata_ff;

endmodule // cms_core

//--- sim/cms_core_checker.sv
`timescale 1ns/1ps

module cms_core_checker
  import cms_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic instr_valid,
  input wire cms_op_t instr_op,
  input wire logic instr_ready,
  input wire logic instr_done,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic stack_pop,
  input wire logic dev_reset,
  input wire logic global_irq_enable,
  input wire logic [7:0] option_out,
  input wire logic [4:0] bank_select
);
  logic take;
  logic take_rd;
  logic take_ret;
  assign take = instr_valid && instr_ready;
  assign take_rd = take && (instr_op inside {CMS_OP_SHL, CMS_OP_SHR, CMS_OP_ROL, CMS_OP_ROR,
    CMS_OP_FMOVE, CMS_OP_ILOAD});
  assign take_ret = take && (instr_op inside {CMS_OP_RET, CMS_OP_RETI, CMS_OP_RETLIT});
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  a_read_op_timing: assert property (
    take_rd |=> mem_rd && !instr_ready ##1 !instr_ready ##1 instr_done)
    else $error("read op timing wrong");
  a_lit_single: assert property (
    take && instr_op == CMS_OP_LIT |=> instr_done && !mem_wr && !mem_rd)
    else $error("literal load not single cycle");
  a_store_write: assert property (
    take && instr_op == CMS_OP_STORE |=> mem_wr && instr_done)
    else $error("store write missing");
  a_return_pop: assert property (
    take_ret |=> stack_pop && !instr_ready ##1 instr_done && !stack_pop)
    else $error("return pop timing wrong");
  a_reti_gie_set: assert property (
    take && instr_op == CMS_OP_RETI |=> global_irq_enable [*2])
    else $error("irq enable not set");
  a_soft_reset: assert property (
    take && instr_op == CMS_OP_SRESET |=> dev_reset ##1 !dev_reset ##[0:1] option_out == 8'hFF)
    else $error("software reset wrong");
  a_option_hold: assert property (
    $changed(option_out) |-> $past(take && instr_op == CMS_OP_OPTION) || $past(dev_reset)
      || dev_reset)
    else $error("option changed without load");
  a_bank_hold: assert property (
    $changed(bank_select) |-> $past(take && instr_op == CMS_OP_BANK) || $past(dev_reset)
      || dev_reset)
    else $error("bank changed without load");
  c_reti: cover property (take && instr_op == CMS_OP_RETI);
  c_sreset: cover property (dev_reset);
  c_iload: cover property (take && instr_op == CMS_OP_ILOAD);
endmodule // cms_core_checker

bind cms_core cms_core_checker u_chk (.clk(clk), .srst(srst), .instr_valid(instr_valid),
  .instr_op(instr_op), .instr_ready(instr_ready), .instr_done(instr_done), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .stack_pop(stack_pop), .dev_reset(dev_reset),
  .global_irq_enable(global_irq_enable), .option_out(option_out), .bank_select(bank_select));

//--- sim/tb_cms_core.sv
`timescale 1ns/1ps
`include "cms_map.svh"

module tb_cms_core
  import cms_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, instr_valid = 1'b0, instr_dest = 1'b0;
  logic instr_ptr_sel = 1'b0, instr_indexed = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  cms_op_t instr_op = CMS_OP_NOP;
  logic [6:0] instr_file = 7'h00, lt;
  logic [10:0] instr_lit = 11'h000;
  logic [1:0] instr_mode = 2'h0;
  logic [5:0] instr_offset = 6'h00;
  logic [7:0] mem_rdata = 8'h00, reg_wdata = 8'h00, mem_wdata, option_out, reg_rdata;
  logic [14:0] stack_top_entry = 15'h0000, stack_push_data, pc_out;
  logic [3:0] reg_addr = 4'h0;
  logic instr_ready, instr_done, mem_rd, mem_wr, stack_push, stack_pop, dev_reset;
  logic global_irq_enable, rd_prev = 1'b0, c = 1'b0, z = 1'b0;
  logic [15:0] mem_addr;
  logic [4:0] bank_select, bk;
  logic [7:0] mem [0:65535];
  logic [7:0] a = 8'h00;
  logic [25:0] q[$];
  int failures = 0;
  int n_compared = 0;

  cms_core dut (.clk(clk), .srst(srst), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_file(instr_file), .instr_dest(instr_dest), .instr_lit(instr_lit),
    .instr_ptr_sel(instr_ptr_sel), .instr_mode(instr_mode), .instr_indexed(instr_indexed),
    .instr_offset(instr_offset), .instr_ready(instr_ready), .instr_done(instr_done),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .stack_push(stack_push), .stack_push_data(stack_push_data),
    .stack_pop(stack_pop), .stack_top_entry(stack_top_entry), .dev_reset(dev_reset),
    .global_irq_enable(global_irq_enable), .option_out(option_out),
    .bank_select(bank_select), .pc_out(pc_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  always #4 clk = ~clk;
  ////////////////////////////////////////
  // data memory: answers one cycle after a read, scrambled otherwise
  always @(posedge clk) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr)
      mem[mem_addr] <= mem_wdata;
  end

  task automatic chk(input logic [25:0] got);
    logic [25:0] e;
    e = (q.size() > 0) ? q.pop_front() : 26'h3FFFFFF;
    n_compared++;
    if (e !== got) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, e);
    end
  endtask

  // result monitor: write, push and register read events in order
  always @(negedge clk) begin
    if (mem_wr)
      chk({2'd1, mem_addr, mem_wdata});
    if (stack_push)
      chk({2'd2, 9'h000, stack_push_data});
    if (rd_prev)
      chk({2'd0, 16'h0000, reg_rdata});
    rd_prev = reg_rd;
  end
  ////////////////////////////////////////
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad, input logic [7:0] d);
    q.push_back({2'd0, 16'h0000, d});
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic ex(input cms_op_t o, input logic [10:0] k, input logic [6:0] f,
    input logic d);
    int n;
    n = 0;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= o;
    instr_lit <= k;
    instr_file <= f;
    instr_dest <= d;
    do @(negedge clk); while (instr_ready !== 1'b1 && n++ < 20);
    @(posedge clk);
    instr_valid <= 1'b0;
    do @(negedge clk); while (instr_done !== 1'b1 && n++ < 40);
    if (n >= 40) begin
      failures++;
      $display("ERROR %0t: instruction never completed", $time);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end
  ////////////////////////////////////////
  initial begin
    logic [7:0] v, r;
    logic [15:0] p, e;
    logic [14:0] t;
    cms_op_t ops[5] = '{CMS_OP_SHL, CMS_OP_SHR, CMS_OP_ROL, CMS_OP_ROR, CMS_OP_FMOVE};
    void'($urandom(32'h1F08));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    wr(4'hF, 8'hAA);
    for (int i = 0; i < 16; i++)
      rd(i[3:0], i == 4 ? 8'hFF : (i == 9 ? 8'h04 : 8'h00));
    a = 8'($urandom);
    bk = 5'($urandom);
    lt = 7'($urandom);
    ex(CMS_OP_LIT, {3'h0, a}, 7'h00, 1'b0);
    rd(`CMS_REG_ACC, a);
    ex(CMS_OP_BANK, {6'h00, bk}, 7'h00, 1'b0);
    ex(CMS_OP_LATCH, {4'h0, lt}, 7'h00, 1'b0);
    ex(CMS_OP_OPTION, 11'h000, 7'h00, 1'b0);
    rd(`CMS_REG_BANK, {3'h0, bk});
    rd(`CMS_REG_LATCH, {1'h0, lt});
    rd(`CMS_REG_OPTION, a);
    q.push_back({2'd1, 4'h0, bk, 7'h7F, a});
    ex(CMS_OP_STORE, 11'h000, 7'h7F, 1'b0);
    rd(`CMS_REG_STATUS, 8'h00);
    // shifts, rotates and moves to both destinations
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'h80 : 8'($urandom);
      e = {4'h0, bk, 7'(7'h40 + i)};
      mem[e] = v;
      case (ops[i / 2])
        CMS_OP_SHL: {c, r} = {v, 1'b0};
        CMS_OP_SHR: {r, c} = {1'b0, v};
        CMS_OP_ROL: {c, r} = {v, c};
        CMS_OP_ROR: {r, c} = {c, v};
        default: r = v;
      endcase
      if (ops[i / 2] inside {CMS_OP_SHL, CMS_OP_SHR, CMS_OP_FMOVE})
        z = (r == 8'h00);
      if (i % 2)
        q.push_back({2'd1, e, r});
      else
        a = r;
      ex(ops[i / 2], 11'h000, e[6:0], 1'(i % 2));
      rd(`CMS_REG_ACC, a);
      rd(`CMS_REG_STATUS, {5'h00, z, 1'b0, c});
    end
    // indirect port through pointer 0
    p = 16'($urandom);
    wr(`CMS_REG_PTR0_LO, p[7:0]);
    wr(`CMS_REG_PTR0_HI, p[15:8]);
    mem[p] = 8'h00;
    a = 8'h00;
    ex(CMS_OP_FMOVE, 11'h000, `CMS_PORT0, 1'b0);
    rd(`CMS_REG_STATUS, {5'h00, 1'b1, 1'b0, c});
    // pointer 1 modes at the wrap boundary, then both offset limits
    wr(`CMS_REG_PTR1_LO, 8'hFF);
    wr(`CMS_REG_PTR1_HI, 8'hFF);
    p = 16'hFFFF;
    instr_ptr_sel <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      instr_mode <= i[1:0];
      instr_indexed <= (i > 7);
      instr_offset <= (i == 8) ? 6'h20 : 6'h1F;
      v = 8'($urandom);
      if (i > 7)
        e = p + ((i == 8) ? 16'hFFE0 : 16'h001F);
      else
        e = i[1] ? p : (i[0] ? p - 16'h0001 : p + 16'h0001);
      mem[e] = v;
      if (i < 8)
        p = i[0] ? p - 16'h0001 : p + 16'h0001;
      if (i[2])
        q.push_back({2'd1, e, a});
      else begin
        a = v;
        z = (v == 8'h00);
      end
      ex(i[2] ? CMS_OP_ISTORE : CMS_OP_ILOAD, 11'h000, 7'h00, 1'b0);
      rd(`CMS_REG_PTR1_LO, p[7:0]);
      rd(`CMS_REG_PTR1_HI, p[15:8]);
      rd(`CMS_REG_ACC, a);
      rd(`CMS_REG_STATUS, {5'h00, z, 1'b0, c});
    end
    // the three returns, then a call
    for (int i = 0; i < 3; i++) begin
      t = 15'($urandom);
      stack_top_entry <= t;
      if (i == 2)
        a = 8'($urandom);
      ex(i == 0 ? CMS_OP_RETI : (i == 1 ? CMS_OP_RET : CMS_OP_RETLIT), {3'h0, a}, 7'h00,
        1'b0);
      rd(`CMS_REG_PC_LO, t[7:0]);
      rd(`CMS_REG_PC_HI, {1'b0, t[14:8]});
      rd(`CMS_REG_ACC, a);
    end
    rd(`CMS_REG_IRQ, 8'h80);
    q.push_back({2'd2, 9'h000, 15'(t + 15'h0001)});
    ex(CMS_OP_CALL, 11'h5A5, 7'h00, 1'b0);
    rd(`CMS_REG_PC_HI, {1'b0, lt[6:3], 3'h5});
    // software reset, then a hardware reset in mid-run
    ex(CMS_OP_SRESET, 11'h000, 7'h00, 1'b0);
    rd(`CMS_REG_POWER_CTRL_REG, 8'h00);
    rd(`CMS_REG_OPTION, 8'hFF);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(`CMS_REG_POWER_CTRL_REG, 8'h04);
    repeat (4) @(posedge clk);
    if (q.size() != 0) begin
      failures++;
      $display("ERROR %0t: %0d results never appeared", $time, q.size());
    end
    finish_test();
  end
endmodule // tb_cms_core
